// file: rtl/mie_exec.sv
// executor for the file increment/decrement, or, rotate and jump instructions
`timescale 1ns/1ps
// Notes on behaviour
// - 7-bit register field, destination flag picks target
// - decrement-skip: skip next when zero, no flags
// - increment-skip: skip next when zero, no flags
// - increment updates only zero flag
// - or literal into accumulator, zero flag only
// - or with register, destination chosen, zero only
// - rotate right through carry, carry only
// - jump loads 11-bit operand into low pc
// - jump fills pc 14:11 from latch 6:3
// - jump takes two cycles, flags unchanged
module mie_exec (
    input wire logic clk_sys, // core instruction clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic cyc_en, // one-cycle enable per instruction cycle
    input wire mie_pkg::mie_instr_type instr_in, // fetched instruction and operand
    input wire logic [6:0] pc_latch_in, // upper pc latch contents
    input wire logic carry_in, // current carry flag
    output mie_pkg::mie_wb_type wb_out, // register write back
    output logic [7:0] acc_out, // accumulator
    output logic [14:0] pc_out, // program counter
    output logic zero_we, // zero flag write strobe
    output logic zero_val, // zero flag value
    output logic carry_we, // carry flag write strobe
    output logic carry_val, // carry flag value
    output logic squash_out, // current slot executes as a no-operation
    output logic [1:0] cycles_out // cycles of last completed instruction
);
    import mie_pkg::*;

    // one instruction slot per cyc_en pulse; between pulses every registered
    // output holds, apart from the one-cycle write strobes and the free-running write-back address, data and flag values

    ////////////////////////////////////////////////////////////////////////
    // decode
    // fields are cut straight from the word; nothing in this section is registered
    mie_state_type state_q; // executing or flushing a slot
    logic [5:0] opc; // byte-group opcode
    logic dest_file; // destination flag
    logic [6:0] faddr; // register field
    logic [7:0] fval; // register operand
    logic [7:0] res; // eight-bit result
    logic to_file; // result goes back to the register
    logic wr_res; // instruction writes a result
    logic is_skip; // skip-type instruction
    logic is_jump; // absolute jump
    logic upd_z; // zero flag affected
    logic upd_c; // carry flag affected
    logic new_c; // carry from the rotate
    logic live; // instruction really executes this cycle
    logic take_two; // taken skip or jump, next slot is thrown away

    // zero test shared by flag and skip decisions
    // (the skip looks at the result itself, never at a zero flag it may not own)
    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    assign opc = instr_in.word[OPC_HI:OPC_LO];
    assign dest_file = instr_in.word[DEST_BIT];
    assign faddr = instr_in.word[FADDR_HI:0];
    assign fval = instr_in.file_data;
    assign is_jump = instr_in.word[OPC_HI:JOPC_LO] == OP_JUMP;
    assign live = cyc_en && instr_in.valid && state_q == ST_EXEC;
    // a taken skip or a jump costs two slots; shared by three processes
    assign take_two = is_jump || (is_skip && is_zero(res));

    // result and flag selection; unknown opcodes write nothing
    always_comb begin
        res = 8'h00;
        wr_res = 1'b1;
        is_skip = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        new_c = carry_in;
        to_file = dest_file;
        // target follows the destination flag; the literal form overrides it
        case (opc)
            OP_DEC_SKIP: begin
                res = fval - 8'h01;
                is_skip = 1'b1;
            end
            OP_INC_SKIP: begin
                res = fval + 8'h01;
                is_skip = 1'b1;
            end
            OP_INC: begin
                res = fval + 8'h01;
                upd_z = 1'b1;
            end
            OP_OR_FILE: begin
                res = acc_out | fval;
                upd_z = 1'b1;
            end
            OP_ROT_RIGHT: begin
                res = {carry_in, fval[7:1]};
                new_c = fval[0];
                upd_c = 1'b1;
            end
            OP_OR_LIT: begin
                res = acc_out | instr_in.word[LIT8_HI:0];
                to_file = 1'b0;
                upd_z = 1'b1;
            end
            default: begin
                wr_res = 1'b0; // jumps and foreign opcodes store nothing
            end
        endcase
        // the jump shares no opcode with the byte group, but is forced quiet
        // anyway so that a later opcode overlap cannot make it write
        if (is_jump) begin
            wr_res = 1'b0;
            upd_z = 1'b0;
            upd_c = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slot sequencing: a taken skip or a jump turns the next slot into a no-operation
    // the spare code is never entered; the default branch walks a stray state
    // back to execute rather than locking the core up
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_EXEC;
        end else if (cyc_en) begin
            case (state_q)
                ST_EXEC: begin
                    if (live && take_two) begin
                        state_q <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    state_q <= ST_EXEC; // flushed slot consumed
                end
                default: begin
                    state_q <= ST_EXEC;
                end
            endcase
        end
    end

    // squash marker for the fetch side, asserted while the flushed slot runs
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            squash_out <= 1'b0;
        end else if (cyc_en) begin
            squash_out <= live && take_two;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator
    // it only moves on an executed slot, so a flushed slot cannot disturb it
    // even though the fetch side still presents a word there
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc_out <= ACC_RST;
        end else if (live && wr_res && !to_file) begin
            acc_out <= res;
        end
    end

    // register write back, one strobe per executed instruction that writes a register
    // address and data follow every cycle; only en qualifies them, which
    // saves an enable on fifteen flops at the cost of busier data lines
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wb_out <= '0;
        end else begin
            wb_out.en <= live && wr_res && to_file;
            wb_out.addr <= faddr;
            wb_out.data <= res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flag strobes; only the flags an instruction owns are written
    // the values run free; the flag file must take them only with a strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            zero_we <= 1'b0;
            zero_val <= 1'b0;
            carry_we <= 1'b0;
            carry_val <= 1'b0;
        end else begin
            zero_we <= live && upd_z;
            zero_val <= is_zero(res);
            carry_we <= live && upd_c;
            carry_val <= new_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter: advance each slot, jump loads the absolute target
    // a slot without an instruction leaves pc alone; a flushed slot still counts
    // limitation: pc simply wraps at the top of its fifteen-bit space
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc_out <= PC_RST;
        end else if (live && is_jump) begin
            // the wide latch field is taken over the narrow reading
            pc_out <= {pc_latch_in[PCU_HI:PCU_LO], instr_in.word[LIT11_HI:0]};
        end else if (cyc_en && (instr_in.valid || state_q == ST_FLUSH)) begin
            pc_out <= pc_out + 15'h0001;
        end
    end

    // cycle count of the instruction that just completed
    // held until the next executed slot, so a flushed slot does not overwrite
    // the two-cycle figure of the instruction that caused it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cycles_out <= CYC_ONE;
        end else if (live) begin
            if (take_two) begin
                cycles_out <= CYC_TWO;
            end else begin
                cycles_out <= CYC_ONE;
            end
        end
    end
endmodule

// file: rtl/mie_pkg.sv
// package: opcodes, field layouts and reset values of the instruction subset executor
package mie_pkg;
    // 14-bit instruction word field positions
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int LIT8_HI = 7;
    localparam int LIT11_HI = 10;
    localparam int JOPC_LO = 11;
    // six-bit opcodes of the byte-oriented group
    localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
    localparam logic [5:0] OP_INC_SKIP = 6'h0F;
    localparam logic [5:0] OP_INC = 6'h0A;
    localparam logic [5:0] OP_OR_FILE = 6'h04;
    localparam logic [5:0] OP_ROT_RIGHT = 6'h0C;
    localparam logic [5:0] OP_OR_LIT = 6'h38;
    // three-bit opcode of the absolute jump
    localparam logic [2:0] OP_JUMP = 3'h5;
    // reset values, and the latch field that fills the upper pc on a jump
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam int PCU_HI = 6;
    localparam int PCU_LO = 3;
    // instruction cycles: one normally, two for a taken skip or a jump
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_FLUSH = 3'b010,
        ST_SPARE = 3'b100
    } mie_state_type;

    // instruction presented by fetch, with the addressed register's value
    typedef struct packed {
        logic valid;
        logic [13:0] word;
        logic [7:0] file_data;
    } mie_instr_type;

    // register-file write back
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } mie_wb_type;
endpackage

// file: tb/mie_exec_chk.sv
// checker: result, flag and timing relations of the executor
`timescale 1ns/1ps
module mie_exec_chk (
    input wire logic clk_sys, // clock
    input wire logic sys_rst, // reset
    input wire logic cyc_en, // slot enable
    input wire mie_pkg::mie_instr_type instr_in, // instruction
    input wire logic [6:0] pc_latch_in, // pc latch
    input wire logic carry_in, // carry
    input wire mie_pkg::mie_wb_type wb_out, // write back
    input wire logic [7:0] acc_out, // acc
    input wire logic [14:0] pc_out, // pc
    input wire logic zero_we, // zero strobe
    input wire logic zero_val, // zero value
    input wire logic carry_we, // carry strobe
    input wire logic carry_val, // carry value
    input wire logic squash_out, // squash
    input wire logic [1:0] cycles_out // cycles
);
    import mie_pkg::*;
    ////////////////////////////////////////////////////////////
    // a slot is only taken outside a flush
    wire t = cyc_en & instr_in.valid & ~squash_out;
    wire [5:0] op = instr_in.word[OPC_HI:OPC_LO];
    wire [7:0] fd = instr_in.file_data;
    wire jmp = t && instr_in.word[OPC_HI:JOPC_LO] == OP_JUMP;
    wire [14:0] jt = {pc_latch_in[PCU_HI:PCU_LO], instr_in.word[LIT11_HI:0]};
    wire [7:0] orl = acc_out | instr_in.word[LIT8_HI:0];
    wire [7:0] orf = acc_out | fd;
    wire dst = instr_in.word[DEST_BIT];
    wire b0 = fd[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    dest_sel_a: assert property (t && op == OP_INC |=> wb_out.en == $past(dst)
        && (wb_out.en || acc_out == $past(fd) + 8'h01)) else $error("dest wrong");
    dec_skip_a: assert property (t && op == OP_DEC_SKIP && fd == 8'h01 |=> squash_out
        && cycles_out == CYC_TWO && !zero_we && !carry_we) else $error("dec skip wrong");
    inc_skip_a: assert property (t && op == OP_INC_SKIP |=>
        squash_out == ($past(fd) == 8'hFF) && !zero_we && !carry_we) else $error("inc skip");
    inc_flags_a: assert property (t && op == OP_INC |=> zero_we
        && zero_val == ($past(fd) == 8'hFF) && !carry_we) else $error("inc flags wrong");
    or_lit_a: assert property (t && op == OP_OR_LIT |=> acc_out == $past(orl)
        && zero_we && cycles_out == CYC_ONE) else $error("or literal wrong");
    or_file_a: assert property (t && op == OP_OR_FILE |=> zero_we && !carry_we
        && wb_out.en == $past(dst)
        && (wb_out.en ? wb_out.data == $past(orf) : acc_out == $past(orf)))
        else $error("or file wrong");
    rot_carry_a: assert property (t && op == OP_ROT_RIGHT |=> carry_we
        && carry_val == $past(b0) && !zero_we) else $error("rotate carry wrong");
    jump_pc_a: assert property (jmp |=> pc_out == $past(jt)) else $error("jump pc");
    jump_cycles_a: assert property (jmp |=> squash_out && cycles_out == CYC_TWO
        && !zero_we && !carry_we) else $error("jump timing wrong");
    pc_step_a: assert property (t && !jmp |=> pc_out == $past(pc_out) + 15'h0001)
        else $error("pc step wrong");
    cover property (t && op == OP_DEC_SKIP && fd == 8'h01);
    cover property (jmp);
    cover property (squash_out && cyc_en);
endmodule
////////////////////////////////////////////////////////////
bind mie_exec mie_exec_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .cyc_en(cyc_en),
    .instr_in(instr_in), .pc_latch_in(pc_latch_in), .carry_in(carry_in), .wb_out(wb_out),
    .acc_out(acc_out), .pc_out(pc_out), .zero_we(zero_we), .zero_val(zero_val),
    .carry_we(carry_we), .carry_val(carry_val), .squash_out(squash_out),
    .cycles_out(cycles_out));

// file: tb/tb_mie_exec.sv
// testbench: corner and random instructions through the executor
`timescale 1ns/1ps
module tb_mie_exec;
    import mie_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc_en = 1'b0;
    mie_instr_type ins = '0;
    logic [6:0] lat = 7'h00;
    logic cin = 1'b0;
    mie_wb_type wb;
    logic [7:0] acc, am;
    logic [14:0] pc;
    logic zwe, zv, cwe, cv, sq;
    logic [1:0] cyc;
    int fails = 0;
    int n_tests = 0;
    bit [31:0] s = 32'h19; // fixed seed
    logic [5:0] opt [6] = '{OP_DEC_SKIP, OP_INC_SKIP, OP_INC, OP_OR_FILE, OP_ROT_RIGHT, OP_OR_LIT};
    always #2 clk_sys = ~clk_sys;
    mie_exec uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cyc_en(cyc_en), .instr_in(ins),
        .pc_latch_in(lat), .carry_in(cin), .wb_out(wb), .acc_out(acc), .pc_out(pc),
        .zero_we(zwe), .zero_val(zv), .carry_we(cwe), .carry_val(cv), .squash_out(sq),
        .cycles_out(cyc));
    ////////////////////////////////////////////////////////////
    // xorshift source, repeatable
    function automatic logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // expected {skip, zero write, carry write, result}
    function automatic logic [10:0] calc(logic [13:0] w, logic [7:0] f, logic c);
        logic [7:0] r;
        case (w[13:8])
            OP_DEC_SKIP: r = f - 8'h01;
            OP_INC_SKIP, OP_INC: r = f + 8'h01;
            OP_OR_FILE: r = am | f;
            OP_ROT_RIGHT: r = {c, f[7:1]};
            OP_OR_LIT: r = am | w[7:0];
            default: r = 8'h00;
        endcase
        return {w[13:8] inside {OP_DEC_SKIP, OP_INC_SKIP} && r == 8'h00,
            w[13:8] inside {OP_INC, OP_OR_FILE, OP_OR_LIT}, w[13:8] == OP_ROT_RIGHT, r};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one slot, then an ignored slot when a skip or jump is taken
    task automatic ex(input logic [13:0] w, input logic [7:0] f);
        logic [10:0] e;
        logic [31:0] r;
        r = rnd();
        e = calc(w, f, r[0]);
        @(posedge clk_sys);
        cyc_en <= 1'b1;
        ins <= '{1'b1, w, f};
        cin <= r[0];
        lat <= r[7:1];
        @(posedge clk_sys);
        cyc_en <= 1'b0;
        #1;
        if (w[13:11] == OP_JUMP) begin
            chk("pc", {r[7:4], w[10:0]}, pc);
            e[10] = 1'b1;
        end else if (w[7] && w[13:8] != OP_OR_LIT) begin
            chk("wb", {1'b1, w[6:0], e[7:0]}, {wb.en, wb.addr, wb.data});
        end else begin
            chk("acc", e[7:0], acc);
            am = e[7:0];
        end
        chk("zero", {e[9], e[9] && e[7:0] == 8'h00}, {zwe, zwe && zv});
        chk("carry", {e[8], e[8] && f[0]}, {cwe, cwe && cv});
        chk("cycles", {e[10], e[10] ? CYC_TWO : CYC_ONE}, {sq, cyc});
        if (e[10]) begin
            @(posedge clk_sys);
            cyc_en <= 1'b1;
            ins <= '{1'b1, {OP_INC, 8'h85}, f};
            @(posedge clk_sys);
            cyc_en <= 1'b0;
            #1;
            chk("flush", 3'h0, {wb.en, zwe, sq});
        end
        $display("test %h done", w);
    endtask
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // corners first, then random traffic
    initial begin
        logic [31:0] r;
        logic [14:0] pq;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("rst", {ACC_RST, 8'h00}, {acc, pc[7:0]});
        am = ACC_RST;
        ex({OP_DEC_SKIP, 8'h85}, 8'h01);
        ex({OP_DEC_SKIP, 8'h05}, 8'h01);
        ex({OP_OR_LIT, 8'h00}, 8'h00);
        ex({OP_INC_SKIP, 8'h7F}, 8'hFF);
        ex({OP_INC, 8'hFF}, 8'hFF);
        ex({OP_OR_FILE, 8'hFF}, 8'h00);
        ex({OP_ROT_RIGHT, 8'h01}, 8'h01);
        ex({OP_JUMP, 11'h7FF}, 8'h00);
        // a slot that carries no instruction changes nothing
        pq = pc;
        @(posedge clk_sys);
        cyc_en <= 1'b1;
        ins.valid <= 1'b0;
        @(posedge clk_sys);
        cyc_en <= 1'b0;
        #1;
        chk("idle pc", pq, pc);
        chk("idle", 3'h0, {wb.en, zwe, cwe});
        $display("test idle done");
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            ex(r[16:14] == 3'h7 ? {OP_JUMP, r[10:0]} : {opt[r[16:14] % 6], r[7:0]}, r[15:8]);
        end
        // reset again in mid-run, then one more slot on the fresh state
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("rst2", {ACC_RST, 1'b0, CYC_ONE}, {acc, sq, cyc});
        chk("rst2 pc", PC_RST, pc);
        am = ACC_RST;
        ex({OP_OR_LIT, 8'h5A}, 8'h33);
        $display("test reset done");
        wrap_up();
    end
endmodule
